// ---- design/iesr_defs.svh ----
`ifndef IESR_DEFS_SVH
`define IESR_DEFS_SVH
// standard event bit positions
`define IESR_SE_OPC 0
`define IESR_SE_HW 3
`define IESR_SE_CANT 4
`define IESR_SE_SYN 5
`define IESR_SE_PWR 7
`define IESR_SE_USED 8'hb9
// device event bit positions
`define IESR_DE_SUSP 5
`define IESR_DE_FULL 10
`define IESR_DE_OPER 11
`define IESR_DE_CAL 12
`define IESR_DE_SWP 13
`define IESR_DE_STEP 14
`define IESR_DE_MEAS 15
`define IESR_DE_USED 16'hfff7
`define IESR_DE_GAP 3
`define IESR_DE_ABOVE 0
// bits that follow a level source instead of latching
`define IESR_DE_LEVEL 16'h0c20
// fault log layout
`define IESR_FL_CAL 2
`define IESR_FL_USED 16'hf6ff
// status byte summary bit positions
`define IESR_STB_DEV 3
`define IESR_STB_STD 5
`endif

// ---- design/iesr_pkg.sv ----
package iesr_pkg;
	typedef enum logic [1:0] {
		IESR_OUT_STANDBY,
		IESR_OUT_SUSPEND,
		IESR_OUT_OPERATE
	} iesr_out_state_t;
	typedef enum logic {
		IESR_OPC_IDLE,
		IESR_OPC_ARMED
	} iesr_opc_state_t;
endpackage : iesr_pkg

// ---- design/iesr_regs.sv ----
// Operation
// - operation complete sets bit 0 once no work pends
// - hardware fault sets standard bit 3
// - cannot-run sets bit 4, misspelling bit 5
// - power cycle sets bit 7; others zero
// - standard flags clear on power, clear, read
// - masks clear at power-on or zero write
// - comparator sets device bits 0..2; 3 zero
// - store count reached sets device bit 4
// - bits 5/11 follow suspend/operate state
// - lower/upper limiter trips set bits 6/7
// - external off/trigger set bits 8/9
// - bit 10 follows buffer full
// - calibration/sweep end set, start clears
// - held step done sets bit 14 unless burst
// - measure end sets 15; start/readout clears
// - device flags except 5,10,11 clear on power, clear, read
// - fault log bits 0,1,6 self-test/flash/source
// - lost calibration bit 2, lost params bit 7
// - overload, fan, heat bits 3..5 sticky
// - calc bit 9, range bit 10; 8,11 zero
// - remote command faults set bits 12..15
// - fault log clears only power or clear
// - masked flags ORed into summary bits 3,5
// - flags latch except device bits 5,10,11; host writes only masks
`timescale 1ns/10ps
`default_nettype none
`include "iesr_defs.svh"
module iesr_regs
	import iesr_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	// command strobes, one cycle, same clock domain
	input wire logic I_OPC_CMD,
	input wire logic I_OPS_PENDING,
	input wire logic I_CLEAR_STATUS,
	input wire logic I_STD_READ,
	input wire logic I_DEV_READ,
	input wire logic I_FAULT_READ,
	input wire logic I_STD_MASK_WR,
	input wire logic [7:0] I_STD_MASK_DATA,
	input wire logic I_DEV_MASK_WR,
	input wire logic [15:0] I_DEV_MASK_DATA,
	// standard event sources, one-cycle pulses
	input wire logic I_HW_FAULT,
	input wire logic I_CANNOT_RUN,
	input wire logic I_SYNTAX_FAULT,
	input wire logic I_POWER_CYCLE,
	// device event sources
	input wire logic I_CMP_ABOVE,
	input wire logic I_CMP_IN_BAND,
	input wire logic I_CMP_UNDER,
	input wire logic I_STORE_COUNT_REACHED,
	input wire logic I_STATE_SUSPEND,
	input wire logic I_STATE_OPERATE,
	input wire logic I_STATE_STANDBY,
	input wire logic I_LIMIT_LOW,
	input wire logic I_LIMIT_HIGH,
	input wire logic I_EXT_OFF_PIN,
	input wire logic I_EXT_TRIG_PIN,
	input wire logic I_BUFFER_FULL,
	input wire logic I_CAL_START,
	input wire logic I_CAL_DONE,
	input wire logic I_SWEEP_START,
	input wire logic I_SWEEP_DONE,
	input wire logic I_STEP_START,
	input wire logic I_STEP_DONE,
	input wire logic I_TRIG_HOLD,
	input wire logic I_BURST_MODE,
	input wire logic I_MEAS_START,
	input wire logic I_MEAS_DONE,
	input wire logic I_MEAS_READOUT,
	// fault log sources, bit per position of the log
	input wire logic [15:0] I_FAULT_SET,
	output logic [7:0] O_STD_FLAGS,
	output logic [15:0] O_DEV_FLAGS,
	output logic [15:0] O_FAULT_LOG,
	output logic [7:0] O_STD_MASK,
	output logic [15:0] O_DEV_MASK,
	output logic O_STB_STD_SUMMARY,
	output logic O_STB_DEV_SUMMARY
);
	// external pins are asynchronous: two stages, then an edge detect
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync_prev;
	logic [1:0] pin_edge;
	iesr_opc_state_t opc_state;
	iesr_out_state_t out_state;
	logic [7:0] std_set;
	logic [15:0] dev_set;
	logic [15:0] dev_clr;
	logic [7:0] next_std;
	logic [15:0] next_dev;
	logic [15:0] next_fault;
	logic opc_fire;

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
			sync_prev <= 2'h0;
		end else begin
			sync1 <= {I_EXT_TRIG_PIN, I_EXT_OFF_PIN};
			sync2 <= sync1;
			sync_prev <= sync2;
		end
	end
	assign pin_edge = sync2 & ~sync_prev;

	// completion waits until the pending work drains after the command
	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			opc_state <= IESR_OPC_IDLE;
		end else begin
			case (opc_state)
				IESR_OPC_IDLE: begin
					if (I_OPC_CMD && I_OPS_PENDING) begin
						opc_state <= IESR_OPC_ARMED;
					end
				end
				IESR_OPC_ARMED: begin
					if (!I_OPS_PENDING || I_CLEAR_STATUS) begin
						opc_state <= IESR_OPC_IDLE;
					end
				end
				default: opc_state <= IESR_OPC_IDLE;
			endcase
		end
	end
	assign opc_fire = (opc_state == IESR_OPC_IDLE && I_OPC_CMD &&
		!I_OPS_PENDING) ||
		(opc_state == IESR_OPC_ARMED && !I_OPS_PENDING);

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			out_state <= IESR_OUT_STANDBY;
		end else if (I_STATE_SUSPEND) begin
			out_state <= IESR_OUT_SUSPEND;
		end else if (I_STATE_OPERATE) begin
			out_state <= IESR_OUT_OPERATE;
		end else if (I_STATE_STANDBY) begin
			out_state <= IESR_OUT_STANDBY;
		end
	end

	always_comb begin
		std_set = 8'h00;
		std_set[`IESR_SE_OPC] = opc_fire;
		std_set[`IESR_SE_HW] = I_HW_FAULT;
		std_set[`IESR_SE_CANT] = I_CANNOT_RUN;
		std_set[`IESR_SE_SYN] = I_SYNTAX_FAULT;
		std_set[`IESR_SE_PWR] = I_POWER_CYCLE;
	end

	always_comb begin
		dev_set = 16'h0000;
		dev_clr = 16'h0000;
		dev_set[2:0] = {I_CMP_UNDER, I_CMP_IN_BAND, I_CMP_ABOVE};
		dev_set[4] = I_STORE_COUNT_REACHED;
		dev_set[7:6] = {I_LIMIT_HIGH, I_LIMIT_LOW};
		dev_set[9:8] = pin_edge;
		dev_set[`IESR_DE_CAL] = I_CAL_DONE;
		dev_clr[`IESR_DE_CAL] = I_CAL_START;
		dev_set[`IESR_DE_SWP] = I_SWEEP_DONE;
		dev_clr[`IESR_DE_SWP] = I_SWEEP_START;
		dev_set[`IESR_DE_STEP] = I_STEP_DONE && I_TRIG_HOLD &&
			!I_BURST_MODE;
		dev_clr[`IESR_DE_STEP] = I_STEP_START || I_SWEEP_START;
		dev_set[`IESR_DE_MEAS] = I_MEAS_DONE;
		dev_clr[`IESR_DE_MEAS] = I_MEAS_START || I_MEAS_READOUT;
	end

	// set beats any clear in the same cycle so no event is lost
	always_comb begin
		next_std = O_STD_FLAGS;
		if (I_CLEAR_STATUS || I_STD_READ) begin
			next_std = 8'h00;
		end
		next_std = (next_std | std_set) & `IESR_SE_USED;
	end

	always_comb begin
		next_dev = O_DEV_FLAGS & ~dev_clr;
		if (I_CLEAR_STATUS || I_DEV_READ) begin
			next_dev = 16'h0000;
		end
		next_dev = (next_dev | dev_set) & `IESR_DE_USED;
		// level-following bits track their source, not latched
		next_dev[`IESR_DE_SUSP] = (out_state == IESR_OUT_SUSPEND);
		next_dev[`IESR_DE_OPER] = (out_state == IESR_OUT_OPERATE);
		next_dev[`IESR_DE_FULL] = I_BUFFER_FULL;
	end

	// a read query never touches the log; I_FAULT_READ is ignored
	always_comb begin
		next_fault = O_FAULT_LOG;
		if (I_CLEAR_STATUS) begin
			next_fault = 16'h0000;
		end
		next_fault = (next_fault | I_FAULT_SET) & `IESR_FL_USED;
	end

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_STD_FLAGS <= 8'h00;
			O_DEV_FLAGS <= 16'h0000;
			O_FAULT_LOG <= 16'h0000;
		end else begin
			O_STD_FLAGS <= next_std;
			O_DEV_FLAGS <= next_dev;
			O_FAULT_LOG <= next_fault;
		end
	end

	// writing zero clears the mask, as any write stores its value
	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_STD_MASK <= 8'h00;
			O_DEV_MASK <= 16'h0000;
		end else begin
			if (I_STD_MASK_WR) begin
				O_STD_MASK <= I_STD_MASK_DATA;
			end
			if (I_DEV_MASK_WR) begin
				O_DEV_MASK <= I_DEV_MASK_DATA;
			end
		end
	end

	// summaries are registered from next values to stay aligned
	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_STB_STD_SUMMARY <= 1'b0;
			O_STB_DEV_SUMMARY <= 1'b0;
		end else begin
			O_STB_STD_SUMMARY <= |(next_std &
				(I_STD_MASK_WR ? I_STD_MASK_DATA : O_STD_MASK));
			O_STB_DEV_SUMMARY <= |(next_dev &
				(I_DEV_MASK_WR ? I_DEV_MASK_DATA : O_DEV_MASK));
		end
	end

	AST_SUMMARY_STD: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		O_STB_STD_SUMMARY == |(O_STD_FLAGS & O_STD_MASK))
		else $error("standard summary mismatch");
	AST_SUMMARY_DEV: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		O_STB_DEV_SUMMARY == |(O_DEV_FLAGS & O_DEV_MASK))
		else $error("device summary mismatch");
	AST_STD_UNUSED: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		(O_STD_FLAGS & ~`IESR_SE_USED) == 8'h00)
		else $error("unused standard bit set");
	AST_STD_READCLR: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		I_STD_READ && !I_HW_FAULT && !I_CANNOT_RUN && !I_SYNTAX_FAULT &&
		!I_POWER_CYCLE && !opc_fire |=> O_STD_FLAGS == 8'h00)
		else $error("standard flags not cleared by read");
	AST_SET_WINS: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		I_HW_FAULT && I_STD_READ |=> O_STD_FLAGS[`IESR_SE_HW])
		else $error("event lost on read clear");
	AST_FAULT_KEEP: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		!I_CLEAR_STATUS |=> (O_FAULT_LOG & $past(O_FAULT_LOG)) ==
		$past(O_FAULT_LOG))
		else $error("fault log lost a bit without clear");
	AST_FAULT_ZERO: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		O_FAULT_LOG[8] == 1'b0 && O_FAULT_LOG[11] == 1'b0)
		else $error("fault log reserved bit set");
	AST_STEP_BURST: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		!O_DEV_FLAGS[`IESR_DE_STEP] && I_BURST_MODE |=>
		!O_DEV_FLAGS[`IESR_DE_STEP])
		else $error("step flag set during burst");
	AST_PIN_TRIG: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		$rose(sync2[1]) |=> O_DEV_FLAGS[9])
		else $error("external trigger not flagged");
	AST_OPER_FOLLOW: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		I_STATE_OPERATE && !I_STATE_SUSPEND |=> ##1
		O_DEV_FLAGS[`IESR_DE_OPER] && !O_DEV_FLAGS[`IESR_DE_SUSP])
		else $error("operate flag did not follow state");
	AST_STD_MASK_ZERO: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		I_STD_MASK_WR && I_STD_MASK_DATA == 8'h00 |=> O_STD_MASK == 8'h00)
		else $error("standard mask not cleared by zero write");
	AST_DEV_MASK_ZERO: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		I_DEV_MASK_WR && I_DEV_MASK_DATA == 16'h0000 |=>
		O_DEV_MASK == 16'h0000)
		else $error("device mask not cleared by zero write");
	AST_DEV_GAP: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		O_DEV_FLAGS[`IESR_DE_GAP] == 1'b0)
		else $error("unused device bit set");
	AST_CMP_ABOVE: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		I_CMP_ABOVE |=> O_DEV_FLAGS[`IESR_DE_ABOVE])
		else $error("above-band result not flagged");
	AST_DEV_READCLR: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		I_DEV_READ && dev_set == 16'h0000 |=>
		(O_DEV_FLAGS & ~`IESR_DE_LEVEL) == 16'h0000)
		else $error("device flags not cleared by read");
	AST_OPC_DONE: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		opc_state == IESR_OPC_ARMED && !I_OPS_PENDING |=>
		O_STD_FLAGS[`IESR_SE_OPC])
		else $error("operation complete not flagged after drain");
	AST_FAULT_CLR: assert property (
		@(posedge I_REF_CLK) disable iff (I_RESET)
		I_CLEAR_STATUS && I_FAULT_SET == 16'h0000 |=> O_FAULT_LOG == 16'h0000)
		else $error("fault log not cleared by clear status");
endmodule : iesr_regs
`default_nettype wire

// ---- tb/iesr_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module iesr_host_model (
	input wire logic i_clk,
	output logic o_clear_status,
	output logic o_std_read,
	output logic o_dev_read,
	output logic o_fault_read,
	output logic o_std_mask_wr,
	output logic [7:0] o_std_mask_data,
	output logic o_dev_mask_wr,
	output logic [15:0] o_dev_mask_data
);
	initial begin
		{o_clear_status, o_std_read, o_dev_read, o_fault_read} = 4'h0;
		{o_std_mask_wr, o_dev_mask_wr} = 2'b00;
		o_std_mask_data = 8'h00;
		o_dev_mask_data = 16'h0000;
	end
	// sel is {clear, std read, dev read, fault read}, one cycle wide
	task automatic strobe(input logic [3:0] sel);
		@(negedge i_clk);
		{o_clear_status, o_std_read, o_dev_read, o_fault_read} = sel;
		@(negedge i_clk);
		{o_clear_status, o_std_read, o_dev_read, o_fault_read} = 4'h0;
	endtask : strobe
	// the host only ever writes masks, never event flags
	task automatic set_masks(input logic [7:0] s, input logic [15:0] d);
		@(negedge i_clk);
		{o_std_mask_wr, o_dev_mask_wr} = 2'b11;
		o_std_mask_data = s;
		o_dev_mask_data = d;
		@(negedge i_clk);
		{o_std_mask_wr, o_dev_mask_wr} = 2'b00;
		// stale data is inverted so a late sample cannot match by luck
		o_std_mask_data = ~s;
		o_dev_mask_data = ~d;
	endtask : set_masks
endmodule : iesr_host_model
`default_nettype wire

// ---- tb/instrument_event_status_regs_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module instrument_event_status_regs_tb_top;
	import iesr_pkg::*;
	typedef struct packed {logic [26:0] ev; logic [7:0] s; logic [15:0] d;} iesr_row_t;
	logic I_REF_CLK, I_RESET, I_OPS_PENDING, I_BUFFER_FULL;
	logic [15:0] I_FAULT_SET, exp;
	logic [26:0] ev;
	int num_errors = 0;
	int samples_checked = 0;
	wire logic I_CLEAR_STATUS, I_STD_READ, I_DEV_READ, I_FAULT_READ;
	wire logic I_STD_MASK_WR, I_DEV_MASK_WR, O_STB_STD_SUMMARY, O_STB_DEV_SUMMARY;
	wire logic [7:0] I_STD_MASK_DATA, O_STD_FLAGS, O_STD_MASK;
	wire logic [15:0] I_DEV_MASK_DATA, O_DEV_FLAGS, O_FAULT_LOG, O_DEV_MASK;
	wire logic I_HW_FAULT = ev[0], I_CANNOT_RUN = ev[1], I_SYNTAX_FAULT = ev[2];
	wire logic I_POWER_CYCLE = ev[3], I_CMP_ABOVE = ev[4], I_CMP_IN_BAND = ev[5];
	wire logic I_CMP_UNDER = ev[6], I_STORE_COUNT_REACHED = ev[7];
	wire logic I_LIMIT_LOW = ev[8], I_LIMIT_HIGH = ev[9], I_CAL_DONE = ev[10];
	wire logic I_SWEEP_DONE = ev[11], I_STEP_DONE = ev[12], I_TRIG_HOLD = ev[13];
	wire logic I_MEAS_DONE = ev[14], I_OPC_CMD = ev[15], I_EXT_OFF_PIN = ev[16];
	wire logic I_EXT_TRIG_PIN = ev[17], I_STATE_SUSPEND = ev[18];
	wire logic I_STATE_OPERATE = ev[19], I_STATE_STANDBY = ev[20];
	wire logic I_CAL_START = ev[21], I_SWEEP_START = ev[22];
	wire logic I_STEP_START = ev[23], I_MEAS_START = ev[24];
	wire logic I_MEAS_READOUT = ev[25], I_BURST_MODE = ev[26];
	iesr_row_t rows [0:19] = '{
		{27'h1, 8'h08, 16'h0}, {27'h2, 8'h10, 16'h0}, {27'h4, 8'h20, 16'h0},
		{27'h8, 8'h80, 16'h0}, {27'hf, 8'hb8, 16'h0}, {27'h10, 8'h0, 16'h1},
		{27'h20, 8'h0, 16'h2}, {27'h40, 8'h0, 16'h4}, {27'h80, 8'h0, 16'h10},
		{27'h100, 8'h0, 16'h40}, {27'h200, 8'h0, 16'h80},
		{27'h400, 8'h0, 16'h1000}, {27'h800, 8'h0, 16'h2000},
		{27'h3000, 8'h0, 16'h4000}, {27'h1000, 8'h0, 16'h0},
		{27'h4003000, 8'h0, 16'h0}, {27'h4000, 8'h0, 16'h8000},
		{27'h8000, 8'h01, 16'h0}, {27'h10000, 8'h0, 16'h100},
		{27'h20000, 8'h0, 16'h200}};
	// done/start pairs: each start must wipe the flag its done raised
	logic [26:0] pairs [0:11] = '{27'h400, 27'h200000, 27'h800, 27'h400000,
		27'h3000, 27'h800000, 27'h4000, 27'h1000000, 27'h4000, 27'h2000000,
		27'h3000, 27'h400000};
	iesr_regs u_iesr_regs (
		.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_OPC_CMD(I_OPC_CMD),
		.I_OPS_PENDING(I_OPS_PENDING), .I_CLEAR_STATUS(I_CLEAR_STATUS),
		.I_STD_READ(I_STD_READ), .I_DEV_READ(I_DEV_READ),
		.I_FAULT_READ(I_FAULT_READ), .I_STD_MASK_WR(I_STD_MASK_WR),
		.I_STD_MASK_DATA(I_STD_MASK_DATA), .I_DEV_MASK_WR(I_DEV_MASK_WR),
		.I_DEV_MASK_DATA(I_DEV_MASK_DATA), .I_HW_FAULT(I_HW_FAULT),
		.I_CANNOT_RUN(I_CANNOT_RUN), .I_SYNTAX_FAULT(I_SYNTAX_FAULT),
		.I_POWER_CYCLE(I_POWER_CYCLE), .I_CMP_ABOVE(I_CMP_ABOVE),
		.I_CMP_IN_BAND(I_CMP_IN_BAND), .I_CMP_UNDER(I_CMP_UNDER),
		.I_STORE_COUNT_REACHED(I_STORE_COUNT_REACHED),
		.I_STATE_SUSPEND(I_STATE_SUSPEND), .I_STATE_OPERATE(I_STATE_OPERATE),
		.I_STATE_STANDBY(I_STATE_STANDBY), .I_LIMIT_LOW(I_LIMIT_LOW),
		.I_LIMIT_HIGH(I_LIMIT_HIGH), .I_EXT_OFF_PIN(I_EXT_OFF_PIN),
		.I_EXT_TRIG_PIN(I_EXT_TRIG_PIN), .I_BUFFER_FULL(I_BUFFER_FULL),
		.I_CAL_START(I_CAL_START), .I_CAL_DONE(I_CAL_DONE),
		.I_SWEEP_START(I_SWEEP_START), .I_SWEEP_DONE(I_SWEEP_DONE),
		.I_STEP_START(I_STEP_START), .I_STEP_DONE(I_STEP_DONE),
		.I_TRIG_HOLD(I_TRIG_HOLD), .I_BURST_MODE(I_BURST_MODE),
		.I_MEAS_START(I_MEAS_START), .I_MEAS_DONE(I_MEAS_DONE),
		.I_MEAS_READOUT(I_MEAS_READOUT), .I_FAULT_SET(I_FAULT_SET),
		.O_STD_FLAGS(O_STD_FLAGS), .O_DEV_FLAGS(O_DEV_FLAGS),
		.O_FAULT_LOG(O_FAULT_LOG), .O_STD_MASK(O_STD_MASK),
		.O_DEV_MASK(O_DEV_MASK), .O_STB_STD_SUMMARY(O_STB_STD_SUMMARY),
		.O_STB_DEV_SUMMARY(O_STB_DEV_SUMMARY));
	iesr_host_model u_iesr_host_model (.i_clk(I_REF_CLK),
		.o_clear_status(I_CLEAR_STATUS), .o_std_read(I_STD_READ),
		.o_dev_read(I_DEV_READ), .o_fault_read(I_FAULT_READ),
		.o_std_mask_wr(I_STD_MASK_WR), .o_std_mask_data(I_STD_MASK_DATA),
		.o_dev_mask_wr(I_DEV_MASK_WR), .o_dev_mask_data(I_DEV_MASK_DATA));
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		if (got !== want) begin
			num_errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk
	task automatic close_out();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	// four idle cycles cover the slowest path, the pin synchroniser
	task automatic pulse(input logic [26:0] v);
		@(negedge I_REF_CLK) ev = v;
		@(negedge I_REF_CLK) ev = '0;
		repeat (4) @(negedge I_REF_CLK);
	endtask : pulse
	initial begin
		I_REF_CLK = 1'b0;
		forever #4 I_REF_CLK = ~I_REF_CLK;
	end
	initial begin
		repeat (5000) @(posedge I_REF_CLK);
		num_errors++;
		close_out();
	end
	initial begin
		{I_RESET, ev, I_FAULT_SET, exp} = {1'b1, 27'h0, 16'h0, 16'h0};
		{I_OPS_PENDING, I_BUFFER_FULL} = 2'b00;
		repeat (2) @(negedge I_REF_CLK);
		I_RESET = 1'b0;
		chk({O_STD_FLAGS, O_STD_MASK}, 16'h0);
		chk(O_DEV_FLAGS | O_FAULT_LOG | O_DEV_MASK, 16'h0);
		foreach (rows[i]) begin
			pulse(rows[i].ev);
			chk({8'h00, O_STD_FLAGS}, {8'h00, rows[i].s});
			chk(O_DEV_FLAGS, rows[i].d);
			u_iesr_host_model.strobe(4'h6);
			chk({O_STD_FLAGS, O_DEV_FLAGS[7:0]} | O_DEV_FLAGS, 16'h0);
		end
		for (int i = 0; i < 12; i += 2) begin
			pulse(pairs[i]);
			pulse(pairs[i + 1]);
			chk(O_DEV_FLAGS, 16'h0);
		end
		u_iesr_host_model.set_masks(8'h08, 16'h0001);
		pulse(27'h11);
		chk({O_STD_MASK, 6'h0, O_STB_STD_SUMMARY, O_STB_DEV_SUMMARY}, 16'h0803);
		u_iesr_host_model.set_masks(8'hf7, 16'hfffe);
		@(negedge I_REF_CLK);
		chk({14'h0, O_STB_STD_SUMMARY, O_STB_DEV_SUMMARY}, 16'h0);
		u_iesr_host_model.set_masks(8'h00, 16'h0000);
		u_iesr_host_model.strobe(4'h8);
		chk({O_STD_MASK, O_STD_FLAGS} | O_DEV_MASK | O_DEV_FLAGS, 16'h0);
		I_OPS_PENDING = 1'b1;
		pulse(27'h8000);
		chk({8'h00, O_STD_FLAGS}, 16'h0);
		I_OPS_PENDING = 1'b0;
		repeat (3) @(negedge I_REF_CLK);
		chk({8'h00, O_STD_FLAGS}, 16'h1);
		fork
			u_iesr_host_model.strobe(4'h4);
			pulse(27'h1);
		join
		chk({8'h00, O_STD_FLAGS}, 16'h8);
		pulse(27'h40000);
		u_iesr_host_model.strobe(4'h2);
		@(negedge I_REF_CLK);
		chk(O_DEV_FLAGS, 16'h0020);
		pulse(27'h80000);
		chk(O_DEV_FLAGS, 16'h0800);
		pulse(27'h100000);
		I_BUFFER_FULL = 1'b1;
		chk(O_DEV_FLAGS, 16'h0);
		repeat (3) @(negedge I_REF_CLK);
		chk(O_DEV_FLAGS, 16'h0400);
		I_BUFFER_FULL = 1'b0;
		repeat (3) @(negedge I_REF_CLK);
		chk(O_DEV_FLAGS, 16'h0);
		for (int i = 0; i < 16; i++) begin
			@(negedge I_REF_CLK) I_FAULT_SET = 16'h1 << i;
			@(negedge I_REF_CLK) I_FAULT_SET = 16'h0;
			exp = exp | ((16'h1 << i) & 16'hf6ff);
			u_iesr_host_model.strobe(4'h7);
			chk(O_FAULT_LOG, exp);
		end
		u_iesr_host_model.strobe(4'h8);
		chk(O_FAULT_LOG, 16'h0);
		// power-on in mid-run: load every register, then pulse reset
		u_iesr_host_model.set_masks(8'hff, 16'hffff);
		I_FAULT_SET = 16'h0001;
		pulse(27'h11);
		I_FAULT_SET = 16'h0000;
		chk({O_STD_FLAGS, 6'h0, O_STB_STD_SUMMARY, O_STB_DEV_SUMMARY}, 16'h0803);
		chk(O_FAULT_LOG | O_DEV_FLAGS, 16'h0001);
		I_RESET = 1'b1;
		repeat (2) @(negedge I_REF_CLK);
		I_RESET = 1'b0;
		chk({O_STD_FLAGS, O_STD_MASK} | O_DEV_MASK, 16'h0);
		chk(O_DEV_FLAGS | O_FAULT_LOG, 16'h0);
		repeat (2) @(negedge I_REF_CLK);
		chk({O_STD_FLAGS, 6'h0, O_STB_STD_SUMMARY, O_STB_DEV_SUMMARY}, 16'h0);
		chk(O_DEV_FLAGS | O_FAULT_LOG, 16'h0);
		close_out();
	end
endmodule : instrument_event_status_regs_tb_top
`default_nettype wire
